// *** spr_addr_chk.sv ***
`timescale 1ns/1ns
`default_nettype none
module spr_addr_chk
  import spr_pkg::*;
(
  input  wire logic        mclk_i,
  input  wire logic        arst_n_i,
  input  wire logic [63:0] operand_i,
  input  wire logic        mode64_i,
  input  wire logic [31:0] ds_base_i,
  input  wire logic [31:0] ds_limit_i,
  output spr_addr_t        chk_o
);

  // ------------------------------------------------------------
  // operand checks, one cycle of latency
  // ------------------------------------------------------------
  spr_addr_t   s_reg;
  spr_addr_t   s_next;
  logic [63:0] lin;
  logic [63:0] off;

  // data segment base applies only outside 64-bit mode
  always_comb begin
    s_next = s_reg;
    if (mode64_i) begin
      lin = operand_i;
    end else begin
      lin = {32'h0000_0000, ds_base_i + operand_i[31:0]};
    end
    off               = lin - SPR_CACHE_BASE;
    s_next.lin        = lin;
    s_next.misalign   = |(lin & SPR_PAGE_MASK);
    s_next.noncanon   = mode64_i &&
                        !((&operand_i[63:SPR_VA_BITS-1]) ||
                          !(|operand_i[63:SPR_VA_BITS-1]));
    s_next.over_limit = !mode64_i && (operand_i[31:0] > ds_limit_i);
    s_next.in_cache   = (lin >= SPR_CACHE_BASE) && (off < SPR_CACHE_SIZE);
    s_next.idx        = off[SPR_PAGE_SHIFT +: SPR_IDX_W];
  end

  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign chk_o = s_reg;

endmodule // spr_addr_chk
`default_nettype wire

// *** spr_meta_mem.sv ***
`timescale 1ns/1ns
`default_nettype none
module spr_meta_mem
  import spr_pkg::*;
(
  input  wire logic                 mclk_i,
  input  wire logic                 arst_n_i,
  input  wire logic                 wr_en_i,
  input  wire logic [SPR_IDX_W-1:0] wr_idx_i,
  input  wire spr_meta_t            wr_data_i,
  input  wire logic [SPR_IDX_W-1:0] rd_idx_i,
  output spr_meta_t                 rd_data_o
);

  // ------------------------------------------------------------
  // storage and registered read
  // ------------------------------------------------------------
  typedef struct packed {
    spr_meta_t [SPR_PAGES-1:0] mem; // one entry per page
    spr_meta_t                 rd;  // read data register
  } spr_mem_st_t;

  spr_mem_st_t s_reg;
  spr_mem_st_t s_next;

  // read sees the old entry on a same-cycle write
  always_comb begin
    s_next    = s_reg;
    s_next.rd = s_reg.mem[rd_idx_i];
    if (wr_en_i) begin
      s_next.mem[wr_idx_i] = wr_data_i;
    end
  end

  // all pages start invalid
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign rd_data_o = s_reg.rd;

endmodule // spr_meta_mem
`default_nettype wire

// *** spr_pkg.sv ***
package spr_pkg;

  // ------------------------------------------------------------
  // command leaves and operand geometry
  // ------------------------------------------------------------
  localparam logic [31:0] SPR_LEAF_REMOVE = 32'h0000_0003; // page removal leaf
  localparam logic [31:0] SPR_LEAF_TRACK  = 32'h0000_000c; // tracking leaf
  localparam logic [1:0]  SPR_CPL_OK      = 2'h0;          // only ring zero may issue
  localparam int          SPR_PAGE_SHIFT  = 12;            // 4 kbyte pages
  localparam logic [63:0] SPR_PAGE_MASK   = 64'h0000_0000_0000_0fff;
  localparam int          SPR_VA_BITS     = 48;            // canonical linear width
  localparam int          SPR_IDX_W       = 6;             // metadata index width
  localparam int          SPR_PAGES       = 64;            // pages in protected cache
  localparam logic [63:0] SPR_CACHE_BASE  = 64'h0000_0000_8000_0000;
  localparam logic [63:0] SPR_CACHE_SIZE  = 64'h0000_0000_0004_0000; // pages * 4k

  // ------------------------------------------------------------
  // answer codes (values arbitrary where none is fixed)
  // ------------------------------------------------------------
  localparam logic [63:0] SPR_OK           = 64'h0000_0000_0000_0000;
  localparam logic [63:0] SPR_ERR_CHILDREN = 64'h0000_0000_0000_0001; // children_remain_err
  localparam logic [63:0] SPR_ERR_ACTIVE   = 64'h0000_0000_0000_0002; // enclave_active_err
  localparam logic [15:0] SPR_EXIT_CONFLICT = 16'h0001; // conflict_exit_reason, arbitrary
  localparam logic [15:0] SPR_QUAL_PAGE     = 16'h0001; // page-conflict code, arbitrary
  localparam logic [15:0] SPR_QUAL_ERR      = 16'h0000; // exit error field

  // ------------------------------------------------------------
  // metadata entry
  // ------------------------------------------------------------
  typedef enum logic [2:0] {
    SPR_PT_CONTROL = 3'h0, // control_page_type
    SPR_PT_REGULAR = 3'h1, // regular_page_type
    SPR_PT_THREAD  = 3'h2, // thread_control_type
    SPR_PT_VERSION = 3'h3, // version_array_type
    SPR_PT_TRIMMED = 3'h4, // trimmed_type
    SPR_SHADOW_STACK_FIRST_TYPE = 3'h5, // shadow_stack_first_type
    SPR_SHADOW_STACK_REST_TYPE = 3'h6  // shadow_stack_rest_type
  } spr_ptype_t;

  typedef struct packed {
    logic       valid;
    logic       modified;
    spr_ptype_t ptype;
  } spr_meta_t;

  localparam int SPR_META_W = $bits(spr_meta_t);

  typedef enum logic [1:0] {
    SPR_FLT_NONE   = 2'h0,
    SPR_FLT_GP     = 2'h1,
    SPR_FLT_PF     = 2'h2,
    SPR_FLT_VMEXIT = 2'h3
  } spr_fault_t;

  typedef struct packed {
    logic carry;
    logic parity;
    logic adjust;
    logic fail;     // fail_flag
    logic sign;
    logic overflow;
  } spr_flags_t;

  typedef struct packed {
    logic        done;
    spr_fault_t  fault;
    logic [63:0] fault_code;  // #gp error code or #pf address
    logic [63:0] result;      // result_reg
    spr_flags_t  flags;
    logic [15:0] exit_reason;
    logic [15:0] exit_qual;
    logic [15:0] exit_err;
    logic [63:0] exit_gpa;
    logic [63:0] exit_gla;
  } spr_resp_t;

  typedef struct packed {
    logic                 misalign;
    logic                 noncanon;
    logic                 over_limit;
    logic                 in_cache;
    logic [SPR_IDX_W-1:0] idx;
    logic [63:0]          lin;
  } spr_addr_t;

endpackage

// *** spr_remove.sv ***
// Summary of operation
// - leaf 03H selects removal, any mode
// - only privilege zero; data segment, no override
// - unaligned operand: general fault zero, after privilege and leaf checks
// - page outside cache: page fault, address
// - page conflict: guest exit, else general fault
// - invalid or clean trimmed: success, no change
// - version array: invalidate, no child or thread check
// - control page with children: fail, stays valid
// - guest virtual child count counts as children only in guest mode with the extension on
// - threads active on child page: fail, active
// - idle enclave: invalidate child page types
// - success zeroes result; always clear arithmetic flags
// - exclusive page hold; conflict outside guest is general fault
// - segment limit general fault; paging page fault
// - non-canonical 64-bit operand: general fault zero
// - tracking leaf: privilege zero, control page operand
`timescale 1ns/1ns
`default_nettype none
module spr_remove
  import spr_pkg::*;
(
  input  wire logic        mclk_i,
  input  wire logic        arst_n_i,
  // command from the instruction front end
  input  wire logic        cmd_valid_i,
  input  wire logic [31:0] leaf_select_reg_i,
  input  wire logic [63:0] operand_reg_i,
  input  wire logic [1:0]  cpl_i,
  input  wire logic        mode64_i,
  input  wire logic [31:0] ds_base_i,
  input  wire logic [31:0] ds_limit_i,
  // context, sampled with the command
  input  wire logic        guest_mode_i,
  input  wire logic        virt_ext_en_i,
  input  wire logic        paging_fault_i,
  input  wire logic [63:0] guest_phys_i,
  input  wire logic        page_busy_i,
  input  wire logic        threads_active_i,
  input  wire logic        child_present_i,
  input  wire logic        virtual_child_nz_i,
  // metadata fill from the page-adding logic
  input  wire logic        meta_fill_valid_i,
  input  wire logic [5:0]  meta_fill_idx_i,
  input  wire spr_meta_t   meta_fill_data_i,
  output logic             meta_fill_ready_o,
  // answer
  output spr_resp_t        resp_o,
  output logic             busy_o,
  output logic             page_lock_o,
  output logic [5:0]       page_lock_idx_o,
  output logic             track_req_o,
  output logic [63:0]      track_addr_o
);

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  typedef enum logic [2:0] {
    SPR_IDLE   = 3'b000, // waiting for a command
    SPR_ADDR   = 3'b001, // operand checker settling
    SPR_CHECK  = 3'b010, // fault and conflict checks
    SPR_READ   = 3'b011, // metadata read in flight
    SPR_DECIDE = 3'b100, // entry inspected, answer formed
    SPR_FINISH = 3'b101  // answer pulse, lock released
  } spr_state_t;

  typedef struct packed {
    spr_state_t           st;
    logic [31:0]          leaf;
    logic [1:0]           cpl;
    logic                 guest_virt;  // guest mode with extension on
    logic                 pg_fault;
    logic [63:0]          gpa;
    logic                 busy_pg;
    logic                 threads;
    logic                 child;
    logic                 vchild;
    logic [63:0]          operand;
    logic                 mode64;
    logic [31:0]          ds_base;
    logic [31:0]          ds_limit;
    logic                 wr_en;       // metadata invalidation strobe
    logic [SPR_IDX_W-1:0] idx;
    spr_meta_t            wr_data;
    spr_resp_t            resp;
    logic                 busy;
    logic                 lock;
    logic                 fill_rdy;
    logic                 track;
    logic [63:0]          track_addr;
  } spr_st_t;

  spr_st_t   s_reg;
  spr_st_t   s_next;
  spr_addr_t chk;
  spr_meta_t rd_meta;
  logic      mem_wr;
  logic [SPR_IDX_W-1:0] mem_wr_idx;
  spr_meta_t mem_wr_data;

  // ------------------------------------------------------------
  // operand checker and metadata map
  // ------------------------------------------------------------
  spr_addr_chk u_chk (
    .mclk_i     (mclk_i),
    .arst_n_i   (arst_n_i),
    .operand_i  (s_reg.operand),
    .mode64_i   (s_reg.mode64),
    .ds_base_i  (s_reg.ds_base),
    .ds_limit_i (s_reg.ds_limit),
    .chk_o      (chk)
  );

  // invalidation owns the write port while a removal runs, so a
  // fill can never slip between the check and the update
  always_comb begin
    mem_wr      = s_reg.wr_en || (meta_fill_valid_i && s_reg.fill_rdy);
    mem_wr_idx  = s_reg.wr_en ? s_reg.idx : meta_fill_idx_i;
    mem_wr_data = s_reg.wr_en ? s_reg.wr_data : meta_fill_data_i;
  end

  spr_meta_mem u_mem (
    .mclk_i    (mclk_i),
    .arst_n_i  (arst_n_i),
    .wr_en_i   (mem_wr),
    .wr_idx_i  (mem_wr_idx),
    .wr_data_i (mem_wr_data),
    .rd_idx_i  (s_reg.idx),
    .rd_data_o (rd_meta)
  );

  // ------------------------------------------------------------
  // command sequencer
  // ------------------------------------------------------------
  // edge by edge after the accepting edge e:
  //   e+1  operand registered into the checker
  //   e+2  faults decided; lock and index taken on a clean path
  //   e+3  metadata entry read out of the map
  //   e+4  entry inspected, answer and write strobe formed
  //   e+5  done pulse, write commits, lock and busy drop
  // a fault skips the read and answers at e+3 instead; the
  // tracking leaf leaves at e+2 with a request pulse only.
  // busy stays high the whole way, so a second command just
  // waits in the front end; nothing here queues requests.
  // context inputs are frozen at e, so a change of guest mode
  // or thread state during the run does not bend the answer.
  always_comb begin
    s_next            = s_reg;
    s_next.wr_en      = 1'b0;
    s_next.track      = 1'b0;
    s_next.resp.done  = 1'b0;
    case (s_reg.st)
      // take a command; context is frozen here
      SPR_IDLE: begin
        if (cmd_valid_i) begin
          s_next.st         = SPR_ADDR;
          s_next.leaf       = leaf_select_reg_i;
          s_next.cpl        = cpl_i;
          s_next.guest_virt = guest_mode_i && virt_ext_en_i;
          s_next.pg_fault   = paging_fault_i;
          s_next.gpa        = guest_phys_i;
          s_next.busy_pg    = page_busy_i;
          s_next.threads    = threads_active_i;
          s_next.child      = child_present_i;
          s_next.vchild     = virtual_child_nz_i;
          s_next.operand    = operand_reg_i;       // segment override ignored
          s_next.mode64     = mode64_i;
          s_next.ds_base    = ds_base_i;
          s_next.ds_limit   = ds_limit_i;
          s_next.busy       = 1'b1;
          s_next.fill_rdy   = 1'b0;
        end
      end
      // checker output is registered; give it one edge
      SPR_ADDR: begin
        s_next.st = SPR_CHECK;
      end
      // fault ordering: privilege, alignment, address form, residency
      SPR_CHECK: begin
        s_next.resp       = '0;
        s_next.resp.fault = SPR_FLT_NONE;
        s_next.idx        = chk.idx;
        s_next.st         = SPR_FINISH;
        if (s_reg.cpl != SPR_CPL_OK) begin
          s_next.resp.fault = SPR_FLT_GP;
        end else if (s_reg.leaf != SPR_LEAF_REMOVE && s_reg.leaf != SPR_LEAF_TRACK) begin
          s_next.resp.fault = SPR_FLT_GP;                  // unknown leaf
        end else if (chk.misalign) begin
          s_next.resp.fault = SPR_FLT_GP;
        end else if (chk.noncanon || chk.over_limit) begin
          s_next.resp.fault = SPR_FLT_GP;
        end else if (s_reg.pg_fault) begin
          s_next.resp.fault      = SPR_FLT_PF;
          s_next.resp.fault_code = chk.lin;
        end else if (s_reg.leaf == SPR_LEAF_TRACK) begin
          // tracking flow lives elsewhere; hand over the control page
          s_next.track      = 1'b1;
          s_next.track_addr = chk.lin;
          s_next.st         = SPR_IDLE;
          s_next.busy       = 1'b0;
          s_next.fill_rdy   = 1'b1;
        end else if (!chk.in_cache) begin
          s_next.resp.fault      = SPR_FLT_PF;
          s_next.resp.fault_code = chk.lin;
        end else if (s_reg.busy_pg) begin
          if (s_reg.guest_virt) begin
            s_next.resp.fault       = SPR_FLT_VMEXIT;
            s_next.resp.exit_reason = SPR_EXIT_CONFLICT;
            s_next.resp.exit_qual   = SPR_QUAL_PAGE;
            s_next.resp.exit_err    = SPR_QUAL_ERR;
            s_next.resp.exit_gpa    = s_reg.gpa;
            s_next.resp.exit_gla    = chk.lin;
          end else begin
            s_next.resp.fault = SPR_FLT_GP;
          end
        end else begin
          // page now held exclusively until the answer
          s_next.lock = 1'b1;
          s_next.st   = SPR_READ;
        end
      end
      // metadata read data lands one edge after the index
      SPR_READ: begin
        s_next.st = SPR_DECIDE;
      end
      // inspect entry and invalidate or fail
      SPR_DECIDE: begin
        s_next.st          = SPR_FINISH;
        s_next.wr_data     = rd_meta;
        s_next.wr_data.valid = 1'b0;
        s_next.resp.result = SPR_OK;
        s_next.resp.flags  = '0;
        if (!rd_meta.valid ||
            (rd_meta.ptype == SPR_PT_TRIMMED && !rd_meta.modified)) begin
          // already unused, or clean trimmed: nothing to write back
          s_next.wr_en = 1'b0;
        end else if (rd_meta.ptype == SPR_PT_VERSION) begin
          s_next.wr_en = 1'b1;
        end else if (rd_meta.ptype == SPR_PT_CONTROL) begin
          if (s_reg.child || (s_reg.guest_virt && s_reg.vchild)) begin
            s_next.resp.flags.fail = 1'b1;
            s_next.resp.result     = SPR_ERR_CHILDREN;
          end else begin
            s_next.wr_en = 1'b1;
          end
        end else if (s_reg.threads) begin
          s_next.resp.flags.fail = 1'b1;
          s_next.resp.result     = SPR_ERR_ACTIVE;
        end else if (rd_meta.ptype == SPR_PT_REGULAR ||
                     rd_meta.ptype == SPR_PT_THREAD ||
                     rd_meta.ptype == SPR_PT_TRIMMED ||
                     rd_meta.ptype == SPR_SHADOW_STACK_FIRST_TYPE ||
                     rd_meta.ptype == SPR_SHADOW_STACK_REST_TYPE) begin
          s_next.wr_en = 1'b1;
        end else begin
          // unknown type code: leave the entry, report success
          s_next.wr_en = 1'b0;
        end
        // arithmetic flags always end cleared; only fail may be set
        s_next.resp.flags.carry    = 1'b0;
        s_next.resp.flags.parity   = 1'b0;
        s_next.resp.flags.adjust   = 1'b0;
        s_next.resp.flags.overflow = 1'b0;
        s_next.resp.flags.sign     = 1'b0;
      end
      // answer pulse; the invalidation write commits on this edge
      SPR_FINISH: begin
        s_next.resp.done = 1'b1;
        s_next.lock      = 1'b0;
        s_next.busy      = 1'b0;
        s_next.fill_rdy  = 1'b1;
        s_next.st        = SPR_IDLE;
      end
      default: begin
        s_next.st       = SPR_IDLE;
        s_next.busy     = 1'b0;
        s_next.lock     = 1'b0;
        s_next.fill_rdy = 1'b1;
      end
    endcase
  end

  // ------------------------------------------------------------
  // state register
  // ------------------------------------------------------------
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      s_reg          <= '0;
      s_reg.st       <= SPR_IDLE;
      s_reg.fill_rdy <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  // ------------------------------------------------------------
  // outputs, all from flops
  // ------------------------------------------------------------
  assign resp_o            = s_reg.resp;
  assign busy_o            = s_reg.busy;
  assign page_lock_o       = s_reg.lock;
  assign page_lock_idx_o   = s_reg.idx;
  assign track_req_o       = s_reg.track;
  assign track_addr_o      = s_reg.track_addr;
  assign meta_fill_ready_o = s_reg.fill_rdy;

endmodule // spr_remove
`default_nettype wire

// *** spr_remove_asserts.sv ***
`timescale 1ns/1ns
`default_nettype none
// ------------------------------------------------------------
// port checker for the removal block
// ------------------------------------------------------------
module spr_remove_asserts
  import spr_pkg::*;
(
  input  wire logic        mclk_i,
  input  wire logic        arst_n_i,
  input  wire logic        cmd_valid_i,
  input  wire logic [31:0] leaf_select_reg_i,
  input  wire logic [63:0] operand_reg_i,
  input  wire logic [1:0]  cpl_i,
  input  wire logic        meta_fill_ready_o,
  input  wire spr_resp_t   resp_o,
  input  wire logic        busy_o,
  input  wire logic        page_lock_o,
  input  wire logic        track_req_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!arst_n_i);
  logic acc; // command taken at this edge
  assign acc = cmd_valid_i && !busy_o;
  property p_accept_busy;
    acc |=> busy_o [*2];
  endproperty
  a_accept_busy: assert property (p_accept_busy) else $error("busy not held");
  property p_cpl_gp;
    acc && cpl_i != 2'h0 |-> ##[3:4] resp_o.done && resp_o.fault == SPR_FLT_GP
      && resp_o.fault_code == 64'h0;
  endproperty
  a_cpl_gp: assert property (p_cpl_gp) else $error("privilege fault missing");
  property p_misalign;
    acc && cpl_i == 2'h0 && leaf_select_reg_i == SPR_LEAF_REMOVE
      && operand_reg_i[11:0] != 12'h0
      |-> ##[3:4] resp_o.done && resp_o.fault == SPR_FLT_GP && resp_o.fault_code == 64'h0;
  endproperty
  a_misalign: assert property (p_misalign) else $error("alignment fault missing");
  property p_flags_clear;
    resp_o.done |-> !(resp_o.flags.carry || resp_o.flags.parity || resp_o.flags.adjust
      || resp_o.flags.overflow || resp_o.flags.sign);
  endproperty
  a_flags_clear: assert property (p_flags_clear) else $error("flags not cleared");
  property p_ok_result;
    resp_o.done && resp_o.fault == SPR_FLT_NONE && !resp_o.flags.fail
      |-> resp_o.result == SPR_OK;
  endproperty
  a_ok_result: assert property (p_ok_result) else $error("success result nonzero");
  property p_fail_code;
    resp_o.done && resp_o.flags.fail |-> resp_o.fault == SPR_FLT_NONE
      && (resp_o.result == SPR_ERR_CHILDREN || resp_o.result == SPR_ERR_ACTIVE);
  endproperty
  a_fail_code: assert property (p_fail_code) else $error("bad failure code");
  property p_exit;
    resp_o.done && resp_o.fault == SPR_FLT_VMEXIT |-> resp_o.exit_reason == SPR_EXIT_CONFLICT
      && resp_o.exit_qual == SPR_QUAL_PAGE && resp_o.exit_err == SPR_QUAL_ERR;
  endproperty
  a_exit: assert property (p_exit) else $error("exit fields wrong");
  property p_lock_busy;
    page_lock_o |-> busy_o;
  endproperty
  a_lock_busy: assert property (p_lock_busy) else $error("lock outside command");
  property p_fill_block;
    busy_o |-> !meta_fill_ready_o;
  endproperty
  a_fill_block: assert property (p_fill_block) else $error("fill open while busy");
  property p_done_pulse;
    resp_o.done |=> !resp_o.done;
  endproperty
  a_done_pulse: assert property (p_done_pulse) else $error("done not a pulse");
  c_fail: cover property (resp_o.done && resp_o.flags.fail);
  c_exit: cover property (resp_o.done && resp_o.fault == SPR_FLT_VMEXIT);
  c_track: cover property (track_req_o);
endmodule // spr_remove_asserts
bind spr_remove spr_remove_asserts u_asserts (.mclk_i(mclk_i), .arst_n_i(arst_n_i),
  .cmd_valid_i(cmd_valid_i), .leaf_select_reg_i(leaf_select_reg_i),
  .operand_reg_i(operand_reg_i), .cpl_i(cpl_i), .meta_fill_ready_o(meta_fill_ready_o),
  .resp_o(resp_o), .busy_o(busy_o), .page_lock_o(page_lock_o), .track_req_o(track_req_o));
`default_nettype wire

// *** spr_sw_model.sv ***
`timescale 1ns/1ns
`default_nettype none
// ------------------------------------------------------------
// system software: issues commands, fills the map
// ------------------------------------------------------------
module spr_sw_model
  import spr_pkg::*;
(
  input  wire logic   mclk_i,
  input  wire logic   busy_i,
  input  wire logic   ready_i,
  output logic        cmd_o,
  output logic [31:0] leaf_o,
  output logic [63:0] op_o,
  output logic [1:0]  cpl_o,
  output logic        fill_o,
  output logic [5:0]  fidx_o,
  output spr_meta_t   fdat_o
);
  initial begin
    cmd_o  = 1'b0;
    leaf_o = 32'h0;
    op_o   = 64'h0;
    cpl_o  = 2'h0;
    fill_o = 1'b0;
    fidx_o = 6'h0;
    fdat_o = '0;
  end
  // hold the request until an edge sees the block idle
  task automatic issue(input logic [31:0] l, input logic [63:0] a, input logic [1:0] c);
    @(posedge mclk_i);
    cmd_o  <= 1'b1;
    leaf_o <= l;
    op_o   <= a;
    cpl_o  <= c;
    do @(posedge mclk_i); while (busy_i);
    cmd_o  <= 1'b0;
    leaf_o <= ~l; // released leaf and operand lines never show stale values
    op_o   <= ~a;
  endtask
  // one map entry, held until ready is seen
  task automatic fill(input logic [5:0] i, input spr_meta_t d);
    @(posedge mclk_i);
    fill_o <= 1'b1;
    fidx_o <= i;
    fdat_o <= d;
    do @(posedge mclk_i); while (!ready_i);
    fill_o <= 1'b0;
    fidx_o <= ~i;
    fdat_o <= ~d;
  endtask
endmodule // spr_sw_model
`default_nettype wire

// *** tb_secure_page_removal.sv ***
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin failures++; \
  $display("mismatch %s exp %h got %h", n, e, g); end end
module tb_secure_page_removal;
  import spr_pkg::*;
  // ------------------------------------------------------------
  // stimulus and observation
  // ------------------------------------------------------------
  logic mclk, arst_n, cmd, fill, ready, busy, lock, treq;
  logic [31:0] leaf, lim, base;
  logic [63:0] op, gpa, taddr;
  logic [1:0] cpl;
  logic [7:0] ctx; // guest ext pgflt busy thr child vchild m64
  logic [5:0] fidx, lidx;
  spr_meta_t fdat, mm [64]; // reference copy of the map
  spr_resp_t resp;
  int failures, samples_checked, seed;
  spr_sw_model sw (.mclk_i(mclk), .busy_i(busy), .ready_i(ready), .cmd_o(cmd), .leaf_o(leaf),
    .op_o(op), .cpl_o(cpl), .fill_o(fill), .fidx_o(fidx), .fdat_o(fdat));
  spr_remove dut (.mclk_i(mclk), .arst_n_i(arst_n), .cmd_valid_i(cmd), .leaf_select_reg_i(leaf),
    .operand_reg_i(op), .cpl_i(cpl), .mode64_i(ctx[7]), .ds_base_i(base), .ds_limit_i(lim),
    .guest_mode_i(ctx[0]), .virt_ext_en_i(ctx[1]), .paging_fault_i(ctx[2]),
    .guest_phys_i(gpa), .page_busy_i(ctx[3]), .threads_active_i(ctx[4]),
    .child_present_i(ctx[5]), .virtual_child_nz_i(ctx[6]), .meta_fill_valid_i(fill),
    .meta_fill_idx_i(fidx), .meta_fill_data_i(fdat), .meta_fill_ready_o(ready), .resp_o(resp),
    .busy_o(busy), .page_lock_o(lock), .page_lock_idx_o(lidx), .track_req_o(treq),
    .track_addr_o(taddr));
  task automatic final_report();
    if (failures == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // one random removal against the reference model
  task automatic run_one();
    logic [31:0] lf, bs; logic [63:0] a, ec, er; logic [1:0] c; logic [7:0] cx; logic ez;
    spr_meta_t md; spr_fault_t ef; int ix, r, lk;
    ix = $random(seed) & 63;
    r = $random(seed) & 15;
    md.valid = 1'($random(seed));
    md.modified = 1'($random(seed));
    md.ptype = spr_ptype_t'(($random(seed) & 32'h7fff_ffff) % 7);
    if (r > 9) begin
      sw.fill(6'(ix), md);
      mm[ix] = md;
    end
    cx = 8'($random(seed));
    cx[2] = (r == 3);
    cx[3] = (($random(seed) & 7) == 0);
    cx[7] = (($random(seed) & 3) != 0);
    lf = SPR_LEAF_REMOVE;
    c = 2'h0;
    a = SPR_CACHE_BASE + (64'(ix) << SPR_PAGE_SHIFT);
    @(posedge mclk);
    lim <= (r == 1 && !cx[7]) ? 32'h0000_1000 : 32'hffff_ffff;
    bs = 32'($random(seed)) & 32'h0000_f000; // page-aligned segment base
    base <= bs;
    if (r == 0) a = a | 64'h0000_0000_0000_0123;
    if (r == 1 && cx[7]) a[63] = 1'b1;
    if (r == 2) a = a + SPR_CACHE_SIZE;
    if (r == 4) c = 2'($random(seed)) | 2'h1;
    if (r == 5) lf = 32'h0000_0005;
    ctx <= cx;
    gpa <= {$random(seed), $random(seed)};
    // expected answer, in fault priority order
    ef = SPR_FLT_NONE; ec = 64'h0; er = SPR_OK; ez = 1'b0;
    if (c != 2'h0 || lf != SPR_LEAF_REMOVE || a[11:0] != 12'h0) ef = SPR_FLT_GP;
    else if (r == 1) ef = SPR_FLT_GP;
    else if (cx[2] || r == 2) begin
      ef = SPR_FLT_PF;
      ec = a;
    end else if (cx[3]) ef = (cx[0] && cx[1]) ? SPR_FLT_VMEXIT : SPR_FLT_GP;
    else if (!mm[ix].valid) ;
    else if (mm[ix].ptype == SPR_PT_TRIMMED && !mm[ix].modified) ;
    else if (mm[ix].ptype == SPR_PT_VERSION) mm[ix].valid = 1'b0;
    else if (mm[ix].ptype == SPR_PT_CONTROL) begin
      if (cx[5] || (cx[0] && cx[1] && cx[6])) {ez, er} = {1'b1, SPR_ERR_CHILDREN};
      else mm[ix].valid = 1'b0;
    end else if (cx[4]) {ez, er} = {1'b1, SPR_ERR_ACTIVE};
    else mm[ix].valid = 1'b0;
    // outside 64-bit mode the segment base is added back by the block
    sw.issue(lf, cx[7] ? a : a - 64'(bs), c);
    // count lock cycles while waiting for the answer
    lk = 0;
    for (r = 0; r < 12 && resp.done !== 1'b1; r++) begin
      @(negedge mclk);
      if (lock === 1'b1) begin
        lk++;
        `CHK("lidx", 6'(ix), lidx)
      end
    end
    `CHK("done", 1'b1, resp.done)
    `CHK("lock", (ef == SPR_FLT_NONE) ? 3 : 0, lk)
    `CHK("fault", ef, resp.fault)
    if (ef == SPR_FLT_GP || ef == SPR_FLT_PF) `CHK("code", ec, resp.fault_code)
    `CHK("result", er, resp.result)
    `CHK("fail", ez, resp.flags.fail)
    if (ef == SPR_FLT_VMEXIT) begin
      `CHK("gpa", gpa, resp.exit_gpa)
      `CHK("gla", a, resp.exit_gla)
    end
  endtask
  // ------------------------------------------------------------
  // clock, reset, sequence, watchdog
  // ------------------------------------------------------------
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  initial begin
    #400000;
    failures++;
    final_report();
  end
  initial begin
    seed = 46;
    arst_n = 1'b0;
    ctx = 8'h80;
    lim = 32'hffff_ffff;
    base = 32'h0;
    gpa = 64'h0;
    foreach (mm[i]) mm[i] = '0;
    repeat (6) @(posedge mclk);
    arst_n <= 1'b1;
    repeat (400) run_one();
    @(posedge mclk);
    ctx <= 8'h80;
    sw.issue(SPR_LEAF_TRACK, SPR_CACHE_BASE, 2'h0);
    for (int k = 0; k < 8 && treq !== 1'b1; k++) @(negedge mclk);
    `CHK("track", 1'b1, treq)
    `CHK("taddr", SPR_CACHE_BASE, taddr)
    final_report();
  end
endmodule // tb_secure_page_removal
`default_nettype wire
